// ---- hdl/rsc_ctrl.sv ----
// Purpose: System reset controller: gathers reset sources, records cause,
//          drives post-reset state of processor modules and system I/O
// Assumes: rst is the power-on reset; pins are asynchronous
// Notes:   Status and mask survive system reset
// How it works
// - Four system sources; VME-in gated by jumper, slot.
// - Watchdog resets one processor, raises level-15 broadcast.
// - Per-processor local reset, diagnostics only.
// - Caches, memory, registers untouched by reset.
// - System reset hits all I/O together.
// - Software VME reset out needs jumper, software times.
// - Switch acts like power-on, recorded in status.
// - System reset sets module state to boot defaults.
// - Watchdog keeps caches; sets boot and watchdog flag.
// - Soft flag: cleared by POR/switch, set by software.
// - Switch flag: cleared by POR/software, set by switch.
// - System reset drives I/O bus reset; VMEbus reset unless VME-in caused it.
// - Reset loads mask, target, slave enable, LEDs.
// - Reset clears IOMMU, soft ints, errors; flushes, timers.
`timescale 1ns/1ps
module rsc_ctrl (
    input  logic                      ref_clk,     // 100 MHz system clock
    input  logic                      rst,         // Power-on reset, async
    input  rsc_pkg::rsc_bus_s         bus,         // Register port request
    output logic [rsc_pkg::DW-1:0]    rdata,       // Read data, one cycle later
    input  rsc_pkg::rsc_pins_s        pins,        // Async reset pins, straps
    input  logic [rsc_pkg::SERR_W-1:0] sys_err_evt, // System error pulses
    output rsc_pkg::rsc_mod_s         mod,         // Processor module controls
    output rsc_pkg::rsc_io_s          io,          // System I/O reset state
    output logic                      irq,         // Level interrupt
    output logic                      bcast_l15    // Level-15 broadcast
);
    import rsc_pkg::*;

    rsc_st_s          q;
    rsc_st_s          d;
    rsc_pins_s        p;
    logic [$bits(rsc_pins_s)-1:0] sync_q;
    logic             sw_edge;
    logic             vme_in_ok;
    logic             sw_req;
    logic             start;
    logic [NPROC-1:0] wd_edge;
    logic [IRQ_W-1:0] ist_set;

    function automatic logic mod_hit(input logic [AW-1:0] a);
        return a[AW-1:4] == OFF_MOD0[AW-1:4];
    endfunction : mod_hit

    // Pin levels from other domains
    rsc_sync #(.W($bits(rsc_pins_s))) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d       (pins),
        .q       (sync_q)
    );
    assign p = rsc_pins_s'(sync_q);

    always_comb begin
        d         = q;
        d.rdata   = '0;

        sw_edge   = p.push_switch_reset & ~q.prev_sw;
        wd_edge   = p.wdog_trap & ~q.prev_wd;
        // Incoming VME reset is ignored when we own slot one
        vme_in_ok = p.vme_reset_in & p.vme_in_jmp & ~p.slot1_master;
        sw_req    = bus.wr && bus.addr == OFF_SCS && bus.wdata[SCS_SWREQ_B];
        start     = sw_edge | vme_in_ok | sw_req;

        d.prev_sw  = p.push_switch_reset;
        d.prev_vme = vme_in_ok;
        d.prev_wd  = p.wdog_trap;

        d.mod.wbuf_flush     = '0;
        d.io.sys_wbuf_flush  = 1'b0;
        d.io.timer_init      = 1'b0;

        // Sticky status: set wins over write-one-to-clear
        ist_set = '0;
        ist_set[IRQ_WDOG_LSB +: NPROC] = wd_edge;
        ist_set[IRQ_SWITCH_B]          = sw_edge;
        ist_set[IRQ_VMEIN_B]           = vme_in_ok & ~q.prev_vme;
        if (bus.wr && bus.addr == OFF_IST) begin
            d.ist = q.ist & ~bus.wdata[IRQ_W-1:0];
        end
        d.ist = d.ist | ist_set;
        d.io.sys_err = d.io.sys_err | sys_err_evt;


        // Register writes
        if (bus.wr && q.fsm == ST_IDLE) begin
            unique case (bus.addr)
                OFF_VME: begin
                    d.vme_sw               = bus.wdata[VME_RSTO_B];
                    d.io.vme_target_enable = bus.wdata[VME_TGT_B];
                end
                OFF_IMSK:  d.imsk        = bus.wdata[IRQ_W-1:0];
                OFF_UMSK:  d.io.umask    = bus.wdata[UMSK_W-1:0];
                OFF_ITGT:  d.io.itgt     = bus.wdata[ITGT_W-1:0];
                OFF_LED:   d.io.leds     = bus.wdata[LED_W-1:0];
                OFF_IOMMU: d.io.iommu_en = bus.wdata[0];
                OFF_SINT:  d.io.soft_int = bus.wdata[SINT_W-1:0];
                OFF_SERR:  d.io.sys_err  = (q.io.sys_err & ~bus.wdata[SERR_W-1:0]) | sys_err_evt;
                default: begin
                end
            endcase
        end

        // Per-processor local resets: only the affected module moves
        for (int i = 0; i < NPROC; i++) begin
            if (q.lcnt[i] != 4'h0) begin
                d.lcnt[i] = q.lcnt[i] - 4'h1;

                if (q.lcnt[i] == 4'h1) begin
                    d.mod.local_rst[i] = 1'b0;
                    d.mod.si[i]        = 1'b0;
                end
            end else if (q.fsm == ST_IDLE && wd_edge[i]) begin
                // Caches, MMU, snoop untouched; buffers drain normally
                d.mod.local_rst[i] = 1'b1;
                d.lcnt[i]          = LOC_HOLD_CYC;
                d.mod.boot_mode[i] = 1'b1;
                d.mod.si[i]        = 1'b0;
                d.mod.wdog_flag[i] = 1'b1;

            end else if (bus.wr && q.fsm == ST_IDLE && mod_hit(bus.addr)
                         && bus.addr[3:2] == 2'(i)) begin
                d.mod.cache_en[i]  = bus.wdata[MOD_CACHE_B];
                d.mod.mmu_en[i]    = bus.wdata[MOD_MMU_B];
                d.mod.snoop_en[i]  = bus.wdata[MOD_SNOOP_B];
                d.mod.boot_mode[i] = bus.wdata[MOD_BOOT_B];
                // Local reset stalls snooping; meant for diagnostics
                if (bus.wdata[MOD_SI_B]) begin
                    d.mod.si[i]        = 1'b1;
                    d.mod.local_rst[i] = 1'b1;
                    d.lcnt[i]          = LOC_HOLD_CYC;
                end
            end
        end

        // System reset sequencer
        unique case (q.fsm)
            ST_IDLE: begin
                if (start) begin
                    d.fsm       = ST_HOLD;
                    d.cnt       = SYS_HOLD_CYC;
                    d.vme_cause = ~sw_edge & ~sw_req;

                    if (sw_edge) begin
                        d.switch_flag = 1'b1;
                        d.soft_flag   = 1'b0;
                    end else if (sw_req) begin
                        d.soft_flag   = 1'b1;
                        d.switch_flag = 1'b0;
                    end
                end
            end
            ST_HOLD: begin
                if (q.cnt != 5'h0) begin
                    d.cnt = q.cnt - 5'h1;
                end else if (!p.push_switch_reset && !vme_in_ok) begin
                    d.fsm = ST_IDLE;
                end
            end
        endcase

        // Whole system held in its initial state; no partial reset.
        // Memory, cache contents and CPU registers are never touched.
        if (d.fsm == ST_HOLD) begin
            d.io.sys_io_rst        = 1'b1;
            d.mod.local_rst        = '1;
            d.lcnt                 = '0;
            d.mod.cache_en         = '0;
            d.mod.mmu_en           = '0;
            d.mod.snoop_en         = '0;
            d.mod.boot_mode        = '1;
            d.mod.si               = '0;
            d.mod.wdog_flag        = '0;
            d.mod.wbuf_flush       = '1;

            d.vme_sw               = 1'b0;

            d.io.umask             = UMSK_RST;
            d.io.vme_target_enable = 1'b0;
            d.io.itgt              = ITGT_RST;
            d.io.leds              = LED_RST;

            d.io.iommu_en          = 1'b0;
            d.io.soft_int          = '0;
            d.io.sys_err           = '0;
            d.io.sys_wbuf_flush    = 1'b1;
            d.io.timer_init        = 1'b1;
        end else if (q.fsm == ST_HOLD) begin
            d.io.sys_io_rst = 1'b0;
            d.mod.local_rst = '0;
        end
        // VME-in cause does not echo back onto the bus it came from
        d.io.vme_rst_out = (d.fsm == ST_HOLD && !d.vme_cause)
                           | (d.vme_sw & p.vme_out_jmp);

        // Read data, registered
        if (bus.rd) begin
            unique case (bus.addr)
                OFF_SCS:   d.rdata = DW'({q.switch_flag, q.soft_flag});
                OFF_VME:   d.rdata = DW'({q.io.vme_target_enable, q.vme_sw});
                OFF_IST:   d.rdata = DW'(q.ist);
                OFF_IMSK:  d.rdata = DW'(q.imsk);
                OFF_UMSK:  d.rdata = DW'(q.io.umask);
                OFF_ITGT:  d.rdata = DW'(q.io.itgt);
                OFF_LED:   d.rdata = DW'(q.io.leds);
                OFF_IOMMU: d.rdata = DW'(q.io.iommu_en);
                OFF_SINT:  d.rdata = DW'(q.io.soft_int);
                OFF_SERR:  d.rdata = DW'(q.io.sys_err);
                default: begin
                    if (mod_hit(bus.addr)) begin
                        d.rdata = DW'({q.mod.wdog_flag[bus.addr[3:2]], q.mod.si[bus.addr[3:2]],
                                       q.mod.boot_mode[bus.addr[3:2]], q.mod.snoop_en[bus.addr[3:2]],
                                       q.mod.mmu_en[bus.addr[3:2]], q.mod.cache_en[bus.addr[3:2]]});
                    end
                end
            endcase
        end

        d.irq   = |(d.ist & d.imsk);
        d.bcast = |d.ist[IRQ_WDOG_LSB +: NPROC];
    end

    // Power-on: both flags cleared, sequencer enters the hold
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q                   <= '0;
            q.fsm               <= ST_HOLD;
            q.cnt               <= SYS_HOLD_CYC;

            q.io.sys_io_rst     <= 1'b1;
            q.io.vme_rst_out    <= 1'b1;
            q.mod.local_rst     <= '1;
            q.mod.boot_mode     <= '1;
            q.io.umask          <= UMSK_RST;
            q.io.leds           <= LED_RST;
        end else begin
            q <= d;
        end
    end

    assign rdata     = q.rdata;
    assign mod       = q.mod;
    assign io        = q.io;
    assign irq       = q.irq;
    assign bcast_l15 = q.bcast;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    property p_soft_flag;
        q.fsm == ST_IDLE && sw_req && !sw_edge |=> q.soft_flag && !q.switch_flag;
    endproperty
    a_soft_flag: assert property (p_soft_flag) else $error("soft flag not set");

    property p_switch_flag;
        q.fsm == ST_IDLE && sw_edge |=> q.switch_flag && !q.soft_flag && q.fsm == ST_HOLD;
    endproperty
    a_switch_flag: assert property (p_switch_flag) else $error("switch flag not set");

    property p_hold_drives;
        q.fsm == ST_HOLD && !q.vme_cause |-> q.io.sys_io_rst && q.io.vme_rst_out;
    endproperty
    a_hold_drives: assert property (p_hold_drives) else $error("bus resets missing");

    property p_io_init;
        q.fsm == ST_HOLD |-> q.io.umask == UMSK_RST && q.io.leds == LED_RST && q.io.itgt == ITGT_RST
                             && !q.io.vme_target_enable && !q.io.iommu_en && q.io.soft_int == '0;
    endproperty
    a_io_init: assert property (p_io_init) else $error("I/O init state wrong");

    property p_mod_init;
        q.fsm == ST_HOLD |-> q.mod.cache_en == '0 && q.mod.mmu_en == '0 && q.mod.snoop_en == '0
                             && q.mod.boot_mode == '1 && q.mod.si == '0 && q.mod.wdog_flag == '0;
    endproperty
    a_mod_init: assert property (p_mod_init) else $error("module init state wrong");

    property p_all_together;
        q.io.sys_io_rst |-> &q.mod.local_rst;
    endproperty
    a_all_together: assert property (p_all_together) else $error("partial system reset");

    property p_wdog;
        q.fsm == ST_IDLE && !start && wd_edge[0] && q.lcnt[0] == 4'h0
        |=> q.mod.local_rst[0] && q.mod.wdog_flag[0] && q.mod.boot_mode[0] && bcast_l15
            && q.mod.cache_en[0] == $past(q.mod.cache_en[0]) && q.mod.snoop_en[0] == $past(q.mod.snoop_en[0]);
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog reset wrong");

    property p_wdog_local;
        q.fsm == ST_IDLE && !start && wd_edge != '0
        |=> $stable(q.soft_flag) && $stable(q.switch_flag) && !q.io.sys_io_rst;
    endproperty
    a_wdog_local: assert property (p_wdog_local) else $error("watchdog touched system");

    property p_slot1_ignore;
        q.fsm == ST_IDLE && p.slot1_master && !sw_edge && !sw_req |=> q.fsm == ST_IDLE;
    endproperty
    a_slot1_ignore: assert property (p_slot1_ignore) else $error("VME-in honoured in slot one");

    property p_vme_jumper;
        !$past(p.vme_out_jmp) && $past(q.fsm) == ST_IDLE && q.fsm == ST_IDLE |-> !q.io.vme_rst_out;
    endproperty
    a_vme_jumper: assert property (p_vme_jumper) else $error("VME reset out without jumper");

    property p_local_len;
        $rose(q.mod.local_rst[0]) && !q.io.sys_io_rst |-> q.mod.local_rst[0] [*8];
    endproperty
    a_local_len: assert property (p_local_len) else $error("local reset too short");

    property p_release;
        q.fsm == ST_HOLD && q.cnt == 5'h0 && !p.push_switch_reset && !vme_in_ok
        |=> q.fsm == ST_IDLE && !q.io.sys_io_rst && q.mod.local_rst == '0;
    endproperty
    a_release: assert property (p_release) else $error("hold not released");

    property p_vme_quiet;
        q.fsm == ST_HOLD && q.vme_cause |-> !q.io.vme_rst_out;
    endproperty
    a_vme_quiet: assert property (p_vme_quiet) else $error("VME-in echoed out");

    property p_flags_hold;
        q.fsm == ST_HOLD |=> $stable(q.soft_flag) && $stable(q.switch_flag);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags moved in hold");

    property p_si;
        q.fsm == ST_IDLE && !start && bus.wr && bus.addr == OFF_MOD0 + 8'h8 && bus.wdata[MOD_SI_B]
        && q.lcnt[2] == 4'h0 && !wd_edge[2] |=> q.mod.si[2] && q.mod.local_rst[2];
    endproperty
    a_si: assert property (p_si) else $error("local reset not started");

    c_soft:   cover property (q.fsm == ST_IDLE && sw_req ##1 q.fsm == ST_HOLD);
    c_switch: cover property (q.fsm == ST_IDLE && sw_edge ##[1:40] q.fsm == ST_IDLE);
    c_wdog:   cover property (q.fsm == ST_IDLE && wd_edge[3] ##1 bcast_l15);
endmodule : rsc_ctrl

// ---- hdl/rsc_pkg.sv ----
// Purpose: Shared constants and types for the system reset controller
// Assumes: 32-bit register port, byte offsets, four processor modules
// Notes:   Offsets, field positions and reset values live only here
package rsc_pkg;
    localparam int NPROC  = 4;
    localparam int AW     = 8;
    localparam int DW     = 32;
    localparam int UMSK_W = 16;
    localparam int ITGT_W = 4;
    localparam int LED_W  = 8;
    localparam int SINT_W = 15;
    localparam int SERR_W = 8;
    localparam int IRQ_W  = 6;

    // Register offsets
    localparam logic [AW-1:0] OFF_SCS   = 8'h00;
    localparam logic [AW-1:0] OFF_VME   = 8'h04;
    localparam logic [AW-1:0] OFF_IST   = 8'h08;
    localparam logic [AW-1:0] OFF_IMSK  = 8'h0c;
    localparam logic [AW-1:0] OFF_UMSK  = 8'h10;
    localparam logic [AW-1:0] OFF_ITGT  = 8'h14;
    localparam logic [AW-1:0] OFF_LED   = 8'h18;
    localparam logic [AW-1:0] OFF_IOMMU = 8'h1c;
    localparam logic [AW-1:0] OFF_SINT  = 8'h20;
    localparam logic [AW-1:0] OFF_SERR  = 8'h24;
    localparam logic [AW-1:0] OFF_MOD0  = 8'h40;

    // Field positions
    localparam int SCS_SOFT_B   = 0;
    localparam int SCS_SWITCH_B = 1;
    localparam int SCS_SWREQ_B  = 2;
    localparam int VME_RSTO_B   = 0;
    localparam int VME_TGT_B    = 1;
    localparam int MOD_CACHE_B  = 0;
    localparam int MOD_MMU_B    = 1;
    localparam int MOD_SNOOP_B  = 2;
    localparam int MOD_BOOT_B   = 3;
    localparam int MOD_SI_B     = 4;
    localparam int MOD_WDOG_B   = 5;
    localparam int IRQ_WDOG_LSB = 0;
    localparam int IRQ_SWITCH_B = 4;
    localparam int IRQ_VMEIN_B  = 5;

    // Reset values
    localparam logic [UMSK_W-1:0] UMSK_RST = 16'hffff;
    localparam logic [ITGT_W-1:0] ITGT_RST = 4'h0;
    localparam logic [LED_W-1:0]  LED_RST  = 8'hff;

    // Timing counts in ref_clk cycles
    localparam logic [4:0] SYS_HOLD_CYC = 5'h10;
    localparam logic [3:0] LOC_HOLD_CYC = 4'h8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_HOLD = 2'b10
    } rsc_fsm_e;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } rsc_bus_s;

    // Asynchronous pins and straps
    typedef struct packed {
        logic             push_switch_reset;
        logic             vme_reset_in;
        logic             vme_in_jmp;
        logic             vme_out_jmp;
        logic             slot1_master;
        logic [NPROC-1:0] wdog_trap;
    } rsc_pins_s;

    typedef struct packed {
        logic [NPROC-1:0] cache_en;
        logic [NPROC-1:0] mmu_en;
        logic [NPROC-1:0] snoop_en;
        logic [NPROC-1:0] boot_mode;
        logic [NPROC-1:0] si;
        logic [NPROC-1:0] wdog_flag;
        logic [NPROC-1:0] wbuf_flush;
        logic [NPROC-1:0] local_rst;
    } rsc_mod_s;

    typedef struct packed {
        logic              sys_io_rst;
        logic              vme_rst_out;
        logic              vme_target_enable;
        logic [UMSK_W-1:0] umask;
        logic [ITGT_W-1:0] itgt;
        logic [LED_W-1:0]  leds;
        logic              iommu_en;
        logic [SINT_W-1:0] soft_int;
        logic [SERR_W-1:0] sys_err;
        logic              sys_wbuf_flush;
        logic              timer_init;
    } rsc_io_s;

    typedef struct packed {
        rsc_fsm_e               fsm;
        logic [4:0]             cnt;
        logic                   soft_flag;
        logic                   switch_flag;
        logic                   vme_cause;
        logic                   vme_sw;
        logic                   prev_sw;
        logic                   prev_vme;
        logic [NPROC-1:0]       prev_wd;
        logic [NPROC-1:0][3:0]  lcnt;
        logic [IRQ_W-1:0]       ist;
        logic [IRQ_W-1:0]       imsk;
        rsc_mod_s               mod;
        rsc_io_s                io;
        logic [DW-1:0]          rdata;
        logic                   irq;
        logic                   bcast;
    } rsc_st_s;
endpackage : rsc_pkg

// ---- hdl/rsc_sync.sv ----
// Purpose: Two-flop synchroniser for a group of asynchronous inputs
// Assumes: Each bit is an independent level
// Notes:   Only the second stage may be read by other logic
`timescale 1ns/1ps
module rsc_sync #(
    parameter int W = 1
) (
    input  logic         ref_clk, // System clock
    input  logic         rst,     // Async reset, active high
    input  logic [W-1:0] d,       // Asynchronous inputs
    output logic [W-1:0] q        // Synchronised levels
);
    logic [W-1:0] meta_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : rsc_sync

// ---- test/rsc_proc_model.sv ----
// Purpose: Processor modules at the far side of the reset controller
// Assumes: Trap requests come from the bench as one-cycle pulses
// Notes:   Trap line drops once the module is held in local reset
`timescale 1ns/1ps
module rsc_proc_model (
    input logic              ref_clk,   // System clock
    input logic [3:0]        trap_req,  // Bench asks for an error trap
    input logic              slow,      // Trap raised six cycles late
    input rsc_pkg::rsc_mod_s mod,       // Module controls
    output logic [3:0]       wdog_trap, // Trap taken with traps off
    output logic [3:0][1:0]  cause      // 1 watchdog, 2 local, 3 system
);
    import rsc_pkg::*;
    int dly [4] = '{default: 0};

    initial begin
        wdog_trap = 4'h0;
        cause = '0;
    end

    always @(posedge ref_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (trap_req[i]) dly[i] <= slow ? 6 : 1;
            else if (dly[i] > 0) dly[i] <= dly[i] - 1;
            if (dly[i] == 1) wdog_trap[i] <= 1'b1;
            // Reset ends the error; cause found by fixed search order
            if (mod.local_rst[i]) begin
                wdog_trap[i] <= 1'b0;
                cause[i] <= mod.wdog_flag[i] ? 2'h1 : (mod.si[i] ? 2'h2 : 2'h3);
            end
        end
    end
endmodule : rsc_proc_model

// ---- test/test_system_reset_controller.sv ----
// Purpose: Self-checking bench for the system reset controller
// Assumes: Pins pass two sync flops; software reset hold is 17 cycles
// Notes:   Reads are noted in a queue and matched by a monitor
`timescale 1ns/1ps
module test_system_reset_controller;
    import rsc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    rsc_bus_s bus = '0;
    rsc_pins_s pins_b = '{vme_out_jmp: 1'b1, default: '0};
    rsc_pins_s pins;
    logic [SERR_W-1:0] sys_err_evt = '0;
    logic [DW-1:0] rdata;
    rsc_mod_s mod;
    rsc_io_s io;
    logic irq, bcast_l15, slow = 1'b0, rd_p = 1'b0;
    logic [3:0] trap_req = 4'h0;
    logic [3:0] wdog_trap;
    logic [3:0][1:0] cause;
    logic [63:0] exp_q [$];
    logic [63:0] note;
    logic [DW-1:0] v;
    int err_count = 0, n_checks = 0, n, p;
    logic [AW-1:0] offs [7] = '{OFF_UMSK, OFF_ITGT, OFF_LED, OFF_IOMMU, OFF_SINT, OFF_VME, OFF_MOD0};
    logic [DW-1:0] msks [7] = '{32'hffff, 32'hf, 32'hff, 32'h1, 32'h7fff, 32'h2, 32'hf};
    logic [DW-1:0] rstv [7] = '{32'hffff, 32'h0, 32'hff, 32'h0, 32'h0, 32'h0, 32'h8};

    always #5 ref_clk = ~ref_clk;
    always_comb begin
        pins = pins_b;
        pins.wdog_trap = wdog_trap;
    end

    rsc_ctrl u_rsc_ctrl (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata), .pins(pins),
        .sys_err_evt(sys_err_evt), .mod(mod), .io(io), .irq(irq), .bcast_l15(bcast_l15));
    rsc_proc_model u_rsc_proc_model (.ref_clk(ref_clk), .trap_req(trap_req), .slow(slow),
        .mod(mod), .wdog_trap(wdog_trap), .cause(cause));

    task automatic give_verdict;
        if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge ref_clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e, input logic [DW-1:0] m);
        @(posedge ref_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        exp_q.push_back({m, e});
        @(posedge ref_clk);
        bus.rd <= 1'b0;
    endtask : rd

    // Data stand only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rd_p) begin
            note = exp_q.pop_front();
            n_checks++;
            if ((rdata & note[63:32]) !== note[31:0]) begin
                err_count++;
                $display("[FAIL] %0t read %h", $time, rdata);
            end
        end
        rd_p <= bus.rd;
    end

    function automatic rsc_io_s io_init(input logic f);
        rsc_io_s x = '0;
        x.sys_io_rst = 1'b1;
        x.vme_rst_out = 1'b1;
        x.umask = 16'hffff;
        x.leds = 8'hff;
        x.sys_wbuf_flush = f;
        x.timer_init = f;
        return x;
    endfunction : io_init

    function automatic rsc_mod_s mod_init(input logic f);
        rsc_mod_s x = '0;
        x.boot_mode = 4'hf;
        x.local_rst = 4'hf;
        x.wbuf_flush = {4{f}};
        return x;
    endfunction : mod_init

    task automatic hold_len(output int c);
        c = 0;
        while (io.sys_io_rst === 1'b1 && c < 300) begin
            c++;
            @(posedge ref_clk);
            #1;
        end
    endtask : hold_len

    task automatic wait_rst(input int lim);
        n = 0;
        while (io.sys_io_rst !== 1'b1 && n < lim) begin
            n++;
            @(posedge ref_clk);
            #1;
        end
    endtask : wait_rst

    task automatic sys_rst(input logic sw, input logic [DW-1:0] scs);
        if (sw) begin
            @(posedge ref_clk);
            pins_b.push_switch_reset <= 1'b1;
            wait_rst(8);
        end else begin
            wr(OFF_SCS, 32'h4);
            #1;
        end
        chk(io === io_init(1'b1) && mod === mod_init(1'b1), "reset state");
        pins_b.push_switch_reset <= 1'b0;
        wr(OFF_UMSK, 32'h0);
        #1;
        hold_len(n);
        chk(sw ? n >= 15 : n == 15, "hold length");
        rd(OFF_SCS, scs, 32'h3);
        rd(OFF_UMSK, 32'hffff, 32'hffff);
    endtask : sys_rst

    initial begin
        v = $urandom(32'h9ce6);
        repeat (3) @(posedge ref_clk);
        #1;
        chk(io === io_init(1'b0) && mod === mod_init(1'b0), "power-on");
        @(posedge ref_clk);
        rst <= 1'b0;
        hold_len(n);
        chk(n < 300, "release");
        rd(OFF_SCS, 32'h0, 32'h3);
        foreach (offs[i]) rd(offs[i], rstv[i], msks[i]);
        wr(8'h30, '1);
        rd(8'h30, 32'h0, '1);
        foreach (offs[i]) begin
            v = $urandom & msks[i];
            wr(offs[i], v);
            rd(offs[i], v, msks[i]);
        end
        for (int k = 0; k < 2; k++) begin
            p = k ? 3 : 0;
            wr(OFF_MOD0 + 8'(4 * p), 32'h7);
            wr(OFF_IMSK, k ? 32'hf : 32'h0);
            slow <= (k == 0);
            trap_req[p] <= 1'b1;
            @(posedge ref_clk);
            trap_req <= 4'h0;
            n = 0;
            while (mod.local_rst[p] !== 1'b1 && n < 20) begin
                n++;
                @(posedge ref_clk);
                #1;
            end
            chk({mod.cache_en[p], mod.mmu_en[p], mod.snoop_en[p], mod.boot_mode[p], mod.si[p],
                mod.wdog_flag[p]} === 6'b111101 && mod.local_rst === (4'h1 << p), "wdog");
            chk(io.sys_io_rst === 1'b0 && bcast_l15 === 1'b1, "broadcast");
            repeat (12) @(posedge ref_clk);
            #1;
            chk(cause[p] === 2'h1 && irq === k[0], "wdog irq");
            rd(OFF_IST, 32'h1 << p, 32'h3f);
            rd(OFF_SCS, 32'h0, 32'h3);
            wr(OFF_IST, 32'h1 << p);
            repeat (2) @(posedge ref_clk);
            #1;
            chk(irq === 1'b0 && bcast_l15 === 1'b0, "cleared");
        end
        // Diagnostic local reset; never issued under multiprocessor load
        wr(OFF_MOD0 + 8'h8, 32'h10);
        #1;
        chk(mod.si[2] === 1'b1 && mod.local_rst === 4'h4, "local");
        repeat (12) @(posedge ref_clk);
        #1;
        chk(cause[2] === 2'h2 && mod.local_rst === 4'h0, "local cause");
        rd(OFF_MOD0 + 8'h8, 32'h0, 32'h10);
        // Pulse width is software's timing loop; not timed here
        wr(OFF_VME, 32'h1);
        repeat (2) @(posedge ref_clk);
        #1;
        chk(io.vme_rst_out === 1'b1, "vme out");
        pins_b.vme_out_jmp <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        chk(io.vme_rst_out === 1'b0, "vme jumper");
        wr(OFF_VME, 32'h0);
        v = $urandom | 32'h1;
        @(posedge ref_clk);
        sys_err_evt <= v[7:0];
        @(posedge ref_clk);
        sys_err_evt <= '0;
        rd(OFF_SERR, v & 32'hff, 32'hff);
        sys_rst(1'b0, 32'h1);
        sys_rst(1'b1, 32'h2);
        sys_rst(1'b0, 32'h1);
        pins_b.slot1_master <= 1'b1;
        pins_b.vme_reset_in <= 1'b1;
        wait_rst(8);
        chk(io.sys_io_rst === 1'b0, "no jumper");
        pins_b.vme_in_jmp <= 1'b1;
        wait_rst(8);
        chk(io.sys_io_rst === 1'b0, "slot one");
        pins_b.slot1_master <= 1'b0;
        wait_rst(8);
        chk(io.sys_io_rst === 1'b1 && io.vme_rst_out === 1'b0, "vme in");
        pins_b.vme_reset_in <= 1'b0;
        hold_len(n);
        rd(OFF_SCS, 32'h1, 32'h3);
        rd(OFF_IST, 32'h30, 32'h3f);
        repeat (4) @(posedge ref_clk);
        give_verdict();
    end

    initial begin
        #100000;
        err_count++;
        give_verdict();
    end
endmodule : test_system_reset_controller
